// file: adccd_params.svh
// Constants for the converter command decoder.
`ifndef ADCCD_PARAMS_SVH
`define ADCCD_PARAMS_SVH
`define ADCCD_OP_REGISTER_READ_CMD_HI      4'h1
`define ADCCD_OP_REGISTER_WRITE_CMD_HI      4'h5
`define ADCCD_OP_INTERNAL_FULL_CALIBRATION_CMD      8'hf0
`define ADCCD_OP_INTERNAL_OFFSET_CALIBRATION_CMD     8'hf1
`define ADCCD_OP_INTERNAL_GAIN_CALIBRATION_CMD     8'hf2
`define ADCCD_OP_EXTERNAL_OFFSET_CALIBRATION_CMD      8'hf3
`define ADCCD_OP_EXTERNAL_GAIN_CALIBRATION_CMD      8'hf4
`define ADCCD_OP_WAKE         8'hfb
`define ADCCD_OP_SYNC         8'hfc
`define ADCCD_OP_SLEEP        8'hfd
`define ADCCD_OP_RESET        8'hfe
`define ADCCD_OP_CONTINUOUS_READOUT_CMD       8'h03
`define ADCCD_OP_END_CONTINUOUS_READOUT_CMD        8'h0f
`define ADCCD_REG_SETUP       4'h0
`define ADCCD_REG_OCR0        4'h7
`define ADCCD_REG_FSR0        4'ha
`define ADCCD_REG_DOR2        4'hd
`define ADCCD_SETUP_SPEED_BIT 4
`define ADCCD_SETUP_RATE_LSB  5
`define ADCCD_SETUP_GAIN_LSB  0
`define ADCCD_RST_DIR         8'hff
`define ADCCD_RST_FSR0        8'h59
`define ADCCD_RST_FSR1        8'h55
`define ADCCD_RST_FSR2        8'h55
`define ADCCD_MOD_DIV_BASE    128
`define ADCCD_DEC_RATIO       1280
`endif

// file: adccd_pkg.sv
// Types shared by the converter command decoder.
package adccd_pkg;
  typedef enum logic [2:0] {
    ADCCD_ST_OP, ADCCD_ST_CNT, ADCCD_ST_RD, ADCCD_ST_WR, ADCCD_ST_CAL
  } adccd_state_t;

  typedef struct packed {
    logic       speed;
    logic [1:0] rate;
    logic [2:0] gain;
  } adccd_cfg_t;

  typedef struct packed {
    logic       offset;
    logic       gain;
    logic       system;
  } adccd_cal_t;
endpackage : adccd_pkg

// file: adccd_decoder.sv
// Serial command decoder with register file, calibration and timing enables.
`timescale 1ns/10ps
`default_nettype none
`include "adccd_params.svh"
module adccd_decoder #(
  parameter int CAL_CYCLES = 64
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Byte streams to and from the serial port.
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  // Converter side.
  input  wire logic        result_valid,
  input  wire logic [23:0] result_code,
  input  wire logic [23:0] cal_offset_value,
  input  wire logic [23:0] cal_gain_value,
  // Status and timing outputs.
  output logic             result_ready_flag_b,
  output logic             sleep_mode,
  output logic             continuous_mode,
  output logic             cal_busy,
  output var adccd_pkg::adccd_cfg_t cfg,
  output logic             mod_tick,
  output logic             samp_tick,
  output logic             conv_tick
);
  // ---------------------------------------------------------------
  // Command decoding and register file
  // ---------------------------------------------------------------
  adccd_pkg::adccd_state_t st_r, st_nxt;
  adccd_pkg::adccd_cal_t   cal_r, cal_nxt;
  logic [7:0]  regs_r [16];
  logic [7:0]  regs_nxt [16];
  logic [3:0]  addr_r, addr_nxt, cnt_r, cnt_nxt;
  logic        is_rd_r, is_rd_nxt;
  logic [15:0] cal_cnt_r, cal_cnt_nxt;
  logic        sleep_r, sleep_nxt, cont_r, cont_nxt, rdy_b_r, rdy_b_nxt;
  logic        sync_r, sync_nxt, txv_r, txv_nxt;
  logic        busy_r, busy_nxt;
  logic [7:0]  txb_r, txb_nxt;
  logic [23:0] code;

  // holds by carrying the two's-complement result unchanged.
  assign code = result_code;

  always_comb begin
    st_nxt      = st_r;
    cal_nxt     = cal_r;
    regs_nxt    = regs_r;
    addr_nxt    = addr_r;
    cnt_nxt     = cnt_r;
    is_rd_nxt   = is_rd_r;
    cal_cnt_nxt = cal_cnt_r;
    sleep_nxt   = sleep_r;
    cont_nxt    = cont_r;
    rdy_b_nxt   = rdy_b_r;
    sync_nxt    = 1'b0;
    txv_nxt     = txv_r && !tx_ready;
    txb_nxt     = txb_r;
    if (result_valid && !sleep_r && st_r != adccd_pkg::ADCCD_ST_CAL) begin
      {regs_nxt[`ADCCD_REG_DOR2], regs_nxt[`ADCCD_REG_DOR2 + 4'h1], regs_nxt[`ADCCD_REG_DOR2 + 4'h2]} = code;
      rdy_b_nxt = 1'b0;
      if (cont_r && !txv_nxt) begin
        txv_nxt = 1'b1;
        txb_nxt = code[23:16];
      end
    end
    unique case (st_r)
      adccd_pkg::ADCCD_ST_OP: begin
        if (rx_valid) begin
          if (rx_byte[7:4] == `ADCCD_OP_REGISTER_READ_CMD_HI || rx_byte[7:4] == `ADCCD_OP_REGISTER_WRITE_CMD_HI) begin
            addr_nxt  = rx_byte[3:0];
            is_rd_nxt = rx_byte[7:4] == `ADCCD_OP_REGISTER_READ_CMD_HI;
            st_nxt    = adccd_pkg::ADCCD_ST_CNT;
          end else if (rx_byte == `ADCCD_OP_WAKE) begin
            sleep_nxt = 1'b0;
          end else if (sleep_r) begin
            sleep_nxt = 1'b1;
          end else if (rx_byte == `ADCCD_OP_SLEEP) begin
            sleep_nxt = 1'b1;
          end else if (rx_byte == `ADCCD_OP_SYNC) begin
            sync_nxt  = 1'b1;
            // A result that lands with the sync still counts, so the ready flag stays set.
            rdy_b_nxt = !result_valid;
          end else if (rx_byte == `ADCCD_OP_RESET) begin
            for (int i = 0; i < 16; i++) regs_nxt[i] = 8'h00;
            regs_nxt[5]  = `ADCCD_RST_DIR;
            regs_nxt[10] = `ADCCD_RST_FSR0;
            regs_nxt[11] = `ADCCD_RST_FSR1;
            regs_nxt[12] = `ADCCD_RST_FSR2;
            cont_nxt  = 1'b0;
            sync_nxt  = 1'b1;
          end else if (rx_byte == `ADCCD_OP_CONTINUOUS_READOUT_CMD) begin
            cont_nxt = 1'b1;
          end else if (rx_byte == `ADCCD_OP_END_CONTINUOUS_READOUT_CMD) begin
            cont_nxt = 1'b0;
          end else if (rx_byte >= `ADCCD_OP_INTERNAL_FULL_CALIBRATION_CMD && rx_byte <= `ADCCD_OP_EXTERNAL_GAIN_CALIBRATION_CMD) begin
            cal_nxt.offset = rx_byte != `ADCCD_OP_INTERNAL_GAIN_CALIBRATION_CMD && rx_byte != `ADCCD_OP_EXTERNAL_GAIN_CALIBRATION_CMD;
            cal_nxt.gain   = rx_byte == `ADCCD_OP_INTERNAL_FULL_CALIBRATION_CMD || rx_byte == `ADCCD_OP_INTERNAL_GAIN_CALIBRATION_CMD
                             || rx_byte == `ADCCD_OP_EXTERNAL_GAIN_CALIBRATION_CMD;
            cal_nxt.system = rx_byte[2] || rx_byte[1:0] == 2'b11;
            cal_cnt_nxt    = 16'(CAL_CYCLES);
            st_nxt         = adccd_pkg::ADCCD_ST_CAL;
          end
          // Any other byte falls through untouched.
        end
      end
      adccd_pkg::ADCCD_ST_CNT: begin
        if (rx_valid) begin
          cnt_nxt = rx_byte[3:0];
          st_nxt  = is_rd_r ? adccd_pkg::ADCCD_ST_RD : adccd_pkg::ADCCD_ST_WR;
        end
      end
      adccd_pkg::ADCCD_ST_RD: begin
        if (!txv_nxt) begin
          txv_nxt  = 1'b1;
          txb_nxt  = regs_r[addr_r];
          addr_nxt = addr_r + 4'h1;
          cnt_nxt  = cnt_r - 4'h1;
          if (cnt_r == 4'h0) st_nxt = adccd_pkg::ADCCD_ST_OP;
        end
      end
      adccd_pkg::ADCCD_ST_WR: begin
        if (rx_valid) begin
          if (addr_r < `ADCCD_REG_DOR2) regs_nxt[addr_r] = rx_byte;
          addr_nxt = addr_r + 4'h1;
          cnt_nxt  = cnt_r - 4'h1;
          if (cnt_r == 4'h0) st_nxt = adccd_pkg::ADCCD_ST_OP;
        end
      end
      adccd_pkg::ADCCD_ST_CAL: begin
        cal_cnt_nxt = cal_cnt_r - 16'h0001;
        if (cal_cnt_r == 16'h0001) begin
          if (cal_r.offset) begin
            {regs_nxt[`ADCCD_REG_OCR0 + 4'h2], regs_nxt[`ADCCD_REG_OCR0 + 4'h1],
             regs_nxt[`ADCCD_REG_OCR0]} = cal_offset_value;
          end
          if (cal_r.gain) begin
            {regs_nxt[`ADCCD_REG_FSR0 + 4'h2], regs_nxt[`ADCCD_REG_FSR0 + 4'h1],
             regs_nxt[`ADCCD_REG_FSR0]} = cal_gain_value;
          end
          st_nxt = adccd_pkg::ADCCD_ST_OP;
        end
      end
    endcase
    busy_nxt = st_nxt == adccd_pkg::ADCCD_ST_CAL;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= adccd_pkg::ADCCD_ST_OP;
      cal_r     <= '0;
      for (int i = 0; i < 16; i++) regs_r[i] <= 8'h00;
      regs_r[5]  <= `ADCCD_RST_DIR;
      regs_r[10] <= `ADCCD_RST_FSR0;
      regs_r[11] <= `ADCCD_RST_FSR1;
      regs_r[12] <= `ADCCD_RST_FSR2;
      addr_r    <= 4'h0;
      cnt_r     <= 4'h0;
      is_rd_r   <= 1'b0;
      cal_cnt_r <= 16'h0000;
      sleep_r   <= 1'b0;
      cont_r    <= 1'b0;
      rdy_b_r   <= 1'b1;
      sync_r    <= 1'b0;
      txv_r     <= 1'b0;
      txb_r     <= 8'h00;
      busy_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cal_r     <= cal_nxt;
      regs_r    <= regs_nxt;
      addr_r    <= addr_nxt;
      cnt_r     <= cnt_nxt;
      is_rd_r   <= is_rd_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      sleep_r   <= sleep_nxt;
      cont_r    <= cont_nxt;
      rdy_b_r   <= rdy_b_nxt;
      sync_r    <= sync_nxt;
      txv_r     <= txv_nxt;
      txb_r     <= txb_nxt;
      busy_r    <= busy_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Rate dividers
  // ---------------------------------------------------------------
  // One free counter gives all three rates; a resync restarts it so the
  // next result lands one full conversion after the command.
  adccd_pkg::adccd_cfg_t cfg_nxt;
  logic [21:0] div_r, div_nxt;
  logic [21:0] conv_len;
  logic [8:0]  mod_len;
  logic [8:0]  samp_len;
  logic        mod_nxt, samp_nxt, conv_nxt;

  always_comb begin
    cfg_nxt.speed = regs_r[`ADCCD_REG_SETUP][`ADCCD_SETUP_SPEED_BIT];
    cfg_nxt.rate  = regs_r[`ADCCD_REG_SETUP][`ADCCD_SETUP_RATE_LSB +: 2];
    cfg_nxt.gain  = regs_r[`ADCCD_REG_SETUP][`ADCCD_SETUP_GAIN_LSB +: 3];
    mod_len  = 9'(`ADCCD_MOD_DIV_BASE) << cfg_nxt.speed;
    conv_len = 22'(`ADCCD_MOD_DIV_BASE * `ADCCD_DEC_RATIO) << (cfg_nxt.speed + cfg_nxt.rate);
    unique case (cfg_nxt.gain)
      3'h4:    samp_len = mod_len >> 1;
      3'h5:    samp_len = mod_len >> 2;
      3'h6,
      3'h7:    samp_len = mod_len >> 3;
      default: samp_len = mod_len;
    endcase
    div_nxt  = (sync_r || div_r + 22'h1 >= conv_len) ? 22'h0 : div_r + 22'h1;
    mod_nxt  = !sleep_r && ((div_r & 22'(mod_len - 9'h1)) == 22'h0);
    samp_nxt = !sleep_r && ((div_r & 22'(samp_len - 9'h1)) == 22'h0);
    conv_nxt = !sleep_r && !sync_r && div_r + 22'h1 >= conv_len;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r     <= 22'h0;
      cfg       <= '0;
      mod_tick  <= 1'b0;
      samp_tick <= 1'b0;
      conv_tick <= 1'b0;
    end else begin
      div_r     <= div_nxt;
      cfg       <= cfg_nxt;
      mod_tick  <= mod_nxt;
      samp_tick <= samp_nxt;
      conv_tick <= conv_nxt;
    end
  end

  assign tx_valid            = txv_r;
  assign tx_byte             = txb_r;
  assign result_ready_flag_b = rdy_b_r;
  assign sleep_mode          = sleep_r;
  assign continuous_mode     = cont_r;
  assign cal_busy            = busy_r;
endmodule : adccd_decoder
`default_nettype wire

// file: adccd_decoder_properties.sv
// Port checker for the converter command decoder.
`timescale 1ns/10ps
`default_nettype none
module adccd_props #(
  parameter int CAL_CYCLES = 64
) (
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       rst_b,
  // Watched ports.
  input wire logic       rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic       tx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       result_valid,
  input wire logic       result_ready_flag_b,
  input wire logic       sleep_mode,
  input wire logic       continuous_mode,
  input wire logic       cal_busy
);
  localparam int CAL_LIM = CAL_CYCLES + 4;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_cal_end; ##[1:CAL_LIM] !cal_busy; endsequence
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte not held");
  property p_cont_on; $rose(continuous_mode) |-> $past(rx_valid && rx_byte == 8'h03); endproperty
  a_cont_on: assert property (p_cont_on) else $error("continuous mode without command");
  property p_cont_off; $fell(continuous_mode) |-> $past(rx_valid && (rx_byte == 8'h0f || rx_byte == 8'hfe)); endproperty
  a_cont_off: assert property (p_cont_off) else $error("continuous mode left without cause");
  property p_sleep_on; $rose(sleep_mode) |-> $past(rx_valid && rx_byte == 8'hfd); endproperty
  a_sleep_on: assert property (p_sleep_on) else $error("sleep without command");
  property p_sleep_off; $fell(sleep_mode) |-> $past(rx_valid && rx_byte == 8'hfb); endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep left without wake");
  property p_cal_start; $rose(cal_busy) |-> $past(rx_valid && rx_byte[7:4] == 4'hf && rx_byte[3:0] <= 4'h4); endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration without command");
  property p_cal_end; $rose(cal_busy) |-> s_cal_end; endproperty
  a_cal_end: assert property (p_cal_end) else $error("calibration did not finish");
  property p_rdy_fall; $fell(result_ready_flag_b) |-> $past(result_valid); endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("ready flag without result");
endmodule : adccd_props
bind adccd_decoder adccd_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (.core_clk(core_clk), .rst_b(rst_b),
  .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .result_valid(result_valid), .result_ready_flag_b(result_ready_flag_b), .sleep_mode(sleep_mode),
  .continuous_mode(continuous_mode), .cal_busy(cal_busy));
`default_nettype wire

// file: adccd_host.sv
// Host model that sends command bytes and takes reply bytes.
`timescale 1ns/10ps
`default_nettype none
module adccd_host (
  // Clock, reset and stall request.
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       stall,
  // Byte streams.
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  output var logic       tx_ready,
  output var logic       rx_valid,
  output var logic [7:0] rx_byte
);
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_byte);
    tx_ready <= rst_b && !stall;
  end
  // The idle line shows the inverse of the last byte, so a stale byte cannot pass for a new one.
  task automatic send(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
    @(posedge core_clk);
  endtask : send
endmodule : adccd_host
`default_nettype wire

// file: adc_command_decoder_tb_top.sv
// Self-checking bench for the converter command decoder.
`timescale 1ns/10ps
`default_nettype none
module adc_command_decoder_tb_top;
  logic core_clk, rst_b, stall, rv, rx_valid, tx_valid, tx_ready, rdy_b, slp, cont, busy, mt, st, ct;
  logic [7:0] rx_byte, tx_byte, regs[16], q[$];
  logic [23:0] code, c_off, c_gain;
  adccd_pkg::adccd_cfg_t cfg;
  integer seed = 32'he012e26f;
  int n_errors = 0, checks = 0, cyc = 0, p, n_conv = 0;
  adccd_decoder #(.CAL_CYCLES(4)) DUT (.core_clk(core_clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .result_valid(rv), .result_code(code),
    .cal_offset_value(c_off), .cal_gain_value(c_gain), .result_ready_flag_b(rdy_b), .sleep_mode(slp),
    .continuous_mode(cont), .cal_busy(busy), .cfg(cfg), .mod_tick(mt), .samp_tick(st), .conv_tick(ct));
  adccd_host u_host (.core_clk(core_clk), .rst_b(rst_b), .stall(stall), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte));
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  function automatic void defaults();
    foreach (regs[i]) regs[i] = 8'h00;
    regs[5] = 8'hff;
    {regs[12], regs[11], regs[10]} = 24'h555559;
  endfunction : defaults
  function automatic int samp_per(input logic sp, input logic [2:0] g);
    return (128 << sp) >> (g == 3'h4 ? 1 : g == 3'h5 ? 2 : g[2:1] == 2'h3 ? 3 : 0);
  endfunction : samp_per
  task automatic wait_got(input int n);
    int w;
    w = 0;
    while (u_host.got.size() < n && w < 400) begin
      @(negedge core_clk);
      w++;
    end
    @(posedge core_clk);
  endtask : wait_got
  task automatic rd(input logic [3:0] a, input logic [3:0] n);
    u_host.got.delete();
    u_host.send({4'h1, a});
    u_host.send({4'($random(seed)), n});
    wait_got(n + 1);
    chk(u_host.got.size(), n + 1);
    for (int i = 0; i <= n; i++) chk(u_host.got[i], regs[4'(a + i)]);
  endtask : rd
  task automatic wr(input logic [3:0] a);
    u_host.send({4'h5, a});
    u_host.send({4'h0, 4'(q.size() - 1)});
    foreach (q[i]) begin
      u_host.send(q[i]);
      if (4'(a + i) < 4'hd) regs[4'(a + i)] = q[i];
    end
  endtask : wr
  task automatic period(input bit samp);
    p = 0;
    do @(negedge core_clk); while ((samp ? st : mt) !== 1'b1);
    do begin
      @(negedge core_clk);
      p++;
    end while ((samp ? st : mt) !== 1'b1 && p < 3000);
    @(posedge core_clk);
  endtask : period
  task automatic idle;
    int w;
    w = 0;
    do begin
      @(negedge core_clk);
      w++;
    end while (busy !== 1'b0 && w < 100);
    @(posedge core_clk);
  endtask : idle
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    stall <= ($random(seed) & 3) == 0;
    cyc <= cyc + 1;
    if (ct === 1'b1) n_conv <= n_conv + 1;
    if (cyc == 30000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    rst_b <= 1'b0;
    rv <= 1'b0;
    code <= 24'h0;
    c_off <= 24'h0;
    c_gain <= 24'h0;
    defaults();
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(4'h0, 4'hf);
    repeat (6) q.push_back(8'($random(seed)));
    q[4][6:5] = 2'h1;
    wr(4'hc);
    rd(4'hb, 4'h6);
    chk(cfg, {regs[0][4], regs[0][6:5], regs[0][2:0]});
    period(1'b0);
    chk(p, 128 << regs[0][4]);
    period(1'b1);
    chk(p, samp_per(regs[0][4], regs[0][2:0]));
    for (int k = 0; k < 5; k++) begin
      c_off <= 24'($random(seed));
      c_gain <= 24'($random(seed));
      u_host.send(8'hf0 + 8'(k));
      idle();
      if (k != 2 && k != 4) {regs[9], regs[8], regs[7]} = c_off;
      if (k != 1 && k != 3) {regs[12], regs[11], regs[10]} = c_gain;
      rd(4'h7, 4'h5);
    end
    u_host.send(8'hfd);
    u_host.send(8'hf0);
    u_host.send(8'h77);
    @(negedge core_clk);
    chk({slp, busy, cont}, 3'b100);
    @(posedge core_clk);
    u_host.send(8'hfb);
    u_host.send(8'h77);
    rd(4'h0, 4'hf);
    chk(slp, 1'b0);
    chk(cont, 1'b0);
    u_host.send(8'h03);
    u_host.got.delete();
    code <= {1'b1, 23'($random(seed))};
    rv <= 1'b1;
    @(posedge core_clk);
    rv <= 1'b0;
    wait_got(1);
    chk(u_host.got[0], code[23:16]);
    chk({cont, rdy_b}, 2'b10);
    u_host.send(8'hfc);
    @(negedge core_clk);
    chk(rdy_b, 1'b1);
    @(posedge core_clk);
    u_host.send(8'h0f);
    {regs[13], regs[14], regs[15]} = code;
    rd(4'hd, 4'h2);
    chk(cont, 1'b0);
    u_host.send(8'h03);
    u_host.send(8'hfe);
    defaults();
    rd(4'h0, 4'hf);
    u_host.got.delete();
    rv <= 1'b1;
    @(posedge core_clk);
    rv <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({cont, 8'(u_host.got.size())}, 9'h0);
    // The shortest conversion lasts 128 times 1280 cycles, longer than the whole run, so no tick may show.
    chk(n_conv, 0);
    wrap_up();
  end
endmodule : adc_command_decoder_tb_top
`default_nettype wire
